// ---- hdl/watchdog_unit.sv ----
// watchdog reset timer: prescaler, counter, registers, reset pulse
// assumes clk_sys is the oscillator clock and rst is the chip reset
//
// Contract
// - 14-bit prescaler carry advances 7-bit counter
// - chip reset clears counters, disables watchdog
// - writing 1Eh then E1h enables counting
// - each full sequence clears and enables
// - once enabled, only chip reset disables
// - overflow drives 96-period high reset pulse
// - select bit set: oscillator divided by two
// - select clear: half standard, full double-speed
// - time-out is 6*(2^14*2^n - 1) clocks
// - counting continues during Idle mode
// - Power-down stops clock, counts hold
// - interrupt wake-up resumes from held count
// - reset wake-up clears and disables
// - restart register write-only, feeds detector
// - period field bits 2:0, resets zero
`timescale 1ns/1ps
module watchdog_unit (
  // clock, reset, freeze
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire wdt_pkg::reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  // power state
  input wire logic power_down,
  // chip reset request
  output logic chip_reset_out
);

  localparam int TW = wdt_pkg::TOTAL_W;
  localparam int PW = wdt_pkg::PRESCALE_W;

  logic enabled_r;
  logic [PW-1:0] prescale_r;
  logic [wdt_pkg::COUNT_W-1:0] counter_r;
  logic [2:0] timeout_select_r;
  logic [1:0] clk_ctl_r;
  logic [6:0] pulse_cnt_r;
  logic reset_out_r;
  logic [7:0] rdata_r;

  logic restart_wr;
  logic restart_pulse;
  logic run;
  logic wclk_en;
  logic count_tick;
  logic overflow;
  logic [TW-1:0] count_value;
  logic [TW-1:0] term_m1;
  logic clk_sel;
  logic dsm;
  logic clk_ctl_wr;

  // last count before the terminal, for time-out field n
  function automatic logic [TW-1:0] last_count(input logic [2:0] n);
    logic [TW:0] terminal;
    terminal = (TW+1)'(1) << (PW + int'(n));
    // terminal is 2^(14+n) - 1 count steps
    last_count = TW'(terminal - (TW+1)'(2));
  endfunction

  // address decode and clock control fields
  assign restart_wr = reg_req.wr
    && (reg_req.addr == wdt_pkg::RESTART_ADDR);
  assign clk_sel = clk_ctl_r[wdt_pkg::CLKCTL_SEL_BIT];
  assign dsm = clk_ctl_r[wdt_pkg::CLKCTL_DSM_BIT];
  // clock control write, restarts the step spacing helper
  assign clk_ctl_wr = reg_req.wr
    && (reg_req.addr == wdt_pkg::CLKCTL_ADDR);

  // combined counter view, counter above prescaler
  assign count_value = {counter_r, prescale_r};
  assign term_m1 = last_count(timeout_select_r);

  // counting runs in Idle, stops in Power-down and during the pulse
  assign run = enabled_r && !power_down && !reset_out_r;

  // terminal compare on each count step, flagged the same cycle
  assign overflow = run && count_tick && !restart_pulse
    && (count_value == term_m1);

  // outputs
  assign chip_reset_out = reset_out_r;
  assign reg_rdata = rdata_r;

  // restart sequence detector, blind while the pulse runs
  wdt_seq_detect u_seq (
    .clk_sys (clk_sys),
    .rst (rst),
    .ce (ce),
    .wr_stb (restart_wr && !reset_out_r),
    .wr_data (reg_req.wdata),
    .restart (restart_pulse)
  );

  // watchdog clock and count step generation
  wdt_tick_gen u_tick (
    .clk_sys (clk_sys),
    .rst (rst),
    .ce (ce),
    .run (run),
    .clear (restart_pulse || overflow || reset_out_r),
    .clock_select (clk_sel),
    .double_speed (dsm),
    .wclk_en (wclk_en),
    .count_tick (count_tick)
  );

  // enable flag: set by sequence, cleared only by chip reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enabled_r <= 1'b0;
    end else if (ce) begin
      if (overflow) begin
        enabled_r <= 1'b0; // overflow is itself a chip reset
      end else if (restart_pulse) begin
        enabled_r <= 1'b1;
      end
    end
  end

  // prescaler and counter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prescale_r <= '0;
      counter_r <= '0;
    end else if (ce) begin
      if (restart_pulse || overflow || reset_out_r) begin
        prescale_r <= '0;
        counter_r <= '0;
      end else if (run && count_tick) begin
        // held while power_down is high, resumes when it drops
        prescale_r <= prescale_r + PW'(1);
        if (&prescale_r) begin
          counter_r <= counter_r + wdt_pkg::COUNT_W'(1);
        end
      end
    end
  end

  // period register, field in bits 2:0
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timeout_select_r <= wdt_pkg::PERIOD_RESET;
    end else if (ce && reg_req.wr
                 && (reg_req.addr == wdt_pkg::PERIOD_ADDR)) begin
      timeout_select_r <= reg_req.wdata[2:0];
    end
  end

  // clock control register: select and double-speed bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clk_ctl_r <= wdt_pkg::CLKCTL_RESET;
    end else if (ce && reg_req.wr
                 && (reg_req.addr == wdt_pkg::CLKCTL_ADDR)) begin
      clk_ctl_r <= reg_req.wdata[1:0];
    end
  end

  // reset pulse: high for the full pulse count after overflow
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reset_out_r <= 1'b0;
      pulse_cnt_r <= 7'h00;
    end else if (ce) begin
      if (overflow) begin
        reset_out_r <= 1'b1;
        pulse_cnt_r <= wdt_pkg::PULSE_LOAD;
      end else if (reset_out_r) begin
        if (pulse_cnt_r == 7'h00) begin
          reset_out_r <= 1'b0;
        end else begin
          pulse_cnt_r <= pulse_cnt_r - 7'h01;
        end
      end
    end
  end

  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (ce) begin
      if (reg_req.rd) begin
        case (reg_req.addr)
          wdt_pkg::PERIOD_ADDR: begin
            rdata_r <= {5'h00, timeout_select_r};
          end
          wdt_pkg::STATUS_ADDR: begin
            rdata_r <= {enabled_r, counter_r};
          end
          wdt_pkg::CLKCTL_ADDR: begin
            rdata_r <= {6'h00, clk_ctl_r};
          end
          default: begin
            // restart register is write-only and reads zero
            rdata_r <= 8'h00;
          end
        endcase
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  // helper: pulse length and last restart byte
  logic [7:0] hi_len_r;
  logic [7:0] prev_byte_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hi_len_r <= 8'h00;
      prev_byte_r <= 8'h00;
    end else if (ce) begin
      if (overflow) begin
        hi_len_r <= 8'h00;
      end else if (reset_out_r) begin
        hi_len_r <= hi_len_r + 8'h01;
      end
      if (restart_wr && !reset_out_r) begin
        prev_byte_r <= reg_req.wdata;
      end
    end
  end

  // helper: ce cycles since the last count step, seen after one step
  logic [3:0] step_gap_r;
  logic step_seen_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      step_gap_r <= 4'h0;
      step_seen_r <= 1'b0;
    end else if (ce) begin
      if (!run || restart_pulse || overflow || clk_ctl_wr) begin
        step_gap_r <= 4'h0; // spacing unknown after a stop or change
        step_seen_r <= 1'b0;
      end else if (count_tick) begin
        step_gap_r <= 4'h1;
        step_seen_r <= 1'b1;
      end else if (step_gap_r != 4'hF) begin
        step_gap_r <= step_gap_r + 4'h1;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking

  default disable iff (rst);

  // checks
  AST_RESET_DISABLED: assert property (disable iff (1'b0)
    rst |=> !enabled_r && (count_value == '0))
    else $error("reset did not clear and disable");

  AST_SEQ_ENABLES: assert property (
    ce && restart_pulse |=> enabled_r && (count_value == '0))
    else $error("restart sequence did not clear and enable");

  AST_NO_DISABLE: assert property (
    enabled_r && !overflow |=> enabled_r)
    else $error("watchdog disabled without chip reset");

  AST_OVF_PULSE: assert property (
    ce && overflow |=> chip_reset_out && !enabled_r)
    else $error("overflow did not start reset pulse");

  AST_PULSE_LEN: assert property (
    $fell(chip_reset_out)
    |-> hi_len_r == 8'(wdt_pkg::PULSE_OSC_PERIODS))
    else $error("reset pulse length is not 96 periods");

  AST_SEL_DIV2: assert property (
    ce && wclk_en && clk_sel
    |=> !wclk_en || $changed(clk_ctl_r))
    else $error("selected watchdog clock not halved");

  AST_X1_DIV2: assert property (
    ce && wclk_en && !dsm
    |=> !wclk_en || $changed(clk_ctl_r))
    else $error("standard mode watchdog clock not halved");

  AST_X2_FULL: assert property (
    ce && count_tick && step_seen_r && dsm && !clk_sel
    |-> step_gap_r == 4'(wdt_pkg::MACHINE_DIV))
    else $error("double speed watchdog clock not full rate");

  AST_HALF_STEP: assert property (
    ce && count_tick && step_seen_r && !(dsm && !clk_sel)
    |-> step_gap_r == 4'(2 * wdt_pkg::MACHINE_DIV))
    else $error("halved count step spacing wrong");

  AST_TIMEOUT: assert property (
    ce && run && count_tick && !restart_pulse
    && (count_value == term_m1) |=> chip_reset_out)
    else $error("terminal count reached without reset");

  AST_PD_HOLD: assert property (
    power_down && !restart_pulse |=> $stable(count_value))
    else $error("count moved during power-down");

  AST_RESTART_WO: assert property (
    reg_req.rd && ce && (reg_req.addr == wdt_pkg::RESTART_ADDR)
    |=> reg_rdata == 8'h00)
    else $error("restart register read not zero");

  AST_PERIOD_RB: assert property (
    reg_req.rd && ce && (reg_req.addr == wdt_pkg::PERIOD_ADDR)
    |=> reg_rdata == {5'h00, $past(timeout_select_r)})
    else $error("period readback wrong");

  AST_SEQ_ORDER: assert property (
    restart_pulse |-> prev_byte_r == wdt_pkg::SEQ_FIRST
    && reg_req.wdata == wdt_pkg::SEQ_SECOND)
    else $error("restart without adjacent byte pair");

  AST_PRESCALE_STEP: assert property (
    ce && count_tick && !restart_pulse && !overflow
    |=> prescale_r == $past(prescale_r) + PW'(1))
    else $error("prescaler did not advance on a count step");

  AST_ENABLE_ONLY_SEQ: assert property (
    !enabled_r && !restart_pulse |=> !enabled_r)
    else $error("watchdog enabled without restart sequence");

  AST_PULSE_CLEAR: assert property (
    chip_reset_out |-> !enabled_r && (count_value == '0))
    else $error("count or enable left set during reset pulse");

  // scenarios
  COV_ENABLE: cover property (ce && restart_pulse && !enabled_r);
  COV_OVERFLOW: cover property (ce && overflow);
  COV_PD_ENABLED: cover property (enabled_r && power_down);
  COV_PULSE_END: cover property ($fell(chip_reset_out));
  COV_HALF_STEP: cover property (ce && count_tick && step_seen_r && clk_sel);

endmodule

// ---- hdl/wdt_pkg.sv ----
// shared constants and types of the watchdog reset timer
// assumes one system clock that is also the oscillator clock
package wdt_pkg;

  // register byte addresses
  localparam logic [7:0] RESTART_ADDR = 8'hA6;
  localparam logic [7:0] PERIOD_ADDR = 8'hA7;
  localparam logic [7:0] STATUS_ADDR = 8'hAE;
  localparam logic [7:0] CLKCTL_ADDR = 8'hAF;

  // restart sequence bytes
  localparam logic [7:0] SEQ_FIRST = 8'h1E;
  localparam logic [7:0] SEQ_SECOND = 8'hE1;

  // field positions and reset values
  localparam int CLKCTL_DSM_BIT = 0;
  localparam int CLKCTL_SEL_BIT = 1;
  localparam int STATUS_EN_BIT = 7;
  localparam logic [2:0] PERIOD_RESET = 3'h0;
  localparam logic [1:0] CLKCTL_RESET = 2'h0;

  // counter geometry
  localparam int PRESCALE_W = 14;
  localparam int COUNT_W = 7;
  localparam int TOTAL_W = PRESCALE_W + COUNT_W;

  // six watchdog clocks per count step
  localparam int MACHINE_DIV = 6;
  localparam logic [2:0] MACHINE_LAST = 3'(MACHINE_DIV - 1);

  // reset pulse length in oscillator periods, oscillator = clk_sys
  localparam int PULSE_OSC_PERIODS = 96;
  localparam logic [6:0] PULSE_LOAD = 7'(PULSE_OSC_PERIODS - 1);

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  // restart sequence detector states
  typedef enum logic {SEQ_WAIT_FIRST, SEQ_WAIT_SECOND} seq_state_type;

endpackage

// ---- hdl/wdt_seq_detect.sv ----
// two-byte restart sequence detector
// assumes wr_stb is one cycle per restart register write
`timescale 1ns/1ps
module wdt_seq_detect (
  // clock, reset, freeze
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // restart register writes
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  // sequence complete
  output logic restart
);

  wdt_pkg::seq_state_type state_r;

  // second byte must be the very next write
  assign restart = ce && wr_stb && (state_r == wdt_pkg::SEQ_WAIT_SECOND)
    && (wr_data == wdt_pkg::SEQ_SECOND);

  // any other byte restarts detection
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= wdt_pkg::SEQ_WAIT_FIRST;
    end else if (ce && wr_stb) begin
      case (state_r)
        wdt_pkg::SEQ_WAIT_FIRST,
        wdt_pkg::SEQ_WAIT_SECOND: begin
          if (restart) begin
            state_r <= wdt_pkg::SEQ_WAIT_FIRST;
          end else if (wr_data == wdt_pkg::SEQ_FIRST) begin
            state_r <= wdt_pkg::SEQ_WAIT_SECOND;
          end else begin
            state_r <= wdt_pkg::SEQ_WAIT_FIRST;
          end
        end
        default: begin
          state_r <= wdt_pkg::SEQ_WAIT_FIRST;
        end
      endcase
    end
  end

endmodule

// ---- hdl/wdt_tick_gen.sv ----
// watchdog clock enable and six-clock count step generator
// assumes clk_sys is the oscillator clock
`timescale 1ns/1ps
module wdt_tick_gen (
  // clock, reset, freeze
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic run,
  input wire logic clear,
  input wire logic clock_select,
  input wire logic double_speed,
  // enables
  output logic wclk_en,
  output logic count_tick
);

  logic half_r;
  logic [2:0] phase_r;
  logic full_speed;

  // undivided only in double speed with select clear
  assign full_speed = double_speed && !clock_select;
  assign wclk_en = run && (full_speed || half_r);
  assign count_tick = wclk_en && (phase_r == wdt_pkg::MACHINE_LAST);

  // divide-by-two phase, stops with run
  always_ff @(posedge clk_sys) begin
    if (rst || (ce && clear)) begin
      half_r <= 1'b0;
    end else if (ce && run) begin
      half_r <= !half_r;
    end
  end

  // six watchdog clocks per count step
  always_ff @(posedge clk_sys) begin
    if (rst || (ce && clear)) begin
      phase_r <= 3'h0;
    end else if (ce && wclk_en) begin
      if (phase_r == wdt_pkg::MACHINE_LAST) begin
        phase_r <= 3'h0;
      end else begin
        phase_r <= phase_r + 3'h1;
      end
    end
  end

endmodule

// ---- testbench/tb_watchdog_unit.sv ----
// self-checking bench for the watchdog reset timer top module
// assumes the design package and modules are compiled first
`timescale 1ns/1ps
module testbench;
  // design connections
  logic clk_sys;
  logic rst;
  logic ce;
  logic power_down;
  wdt_pkg::reg_req_type req;
  logic [7:0] reg_rdata;
  logic chip_reset_out;
  int err_count;
  int compares;
  logic [7:0] rd_val;
  // six oscillator clocks per step with double speed, field value zero
  localparam int TIMEOUT_CLKS =
    wdt_pkg::MACHINE_DIV * ((1 << wdt_pkg::PRESCALE_W) - 1);
  localparam int FREEZE_CLKS = 500;
  // clock-enable freeze, then the full expected overflow delay
  localparam int HOLD_CLKS = 100;
  localparam int EXPECT_CLKS = TIMEOUT_CLKS + FREEZE_CLKS + HOLD_CLKS;

  watchdog_unit watchdog_unit_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .reg_req(req),
    .reg_rdata(reg_rdata),
    .power_down(power_down),
    .chip_reset_out(chip_reset_out)
  );

  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // compare seen against expected and count
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one-cycle register write
  task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask

  // one-cycle register read, data taken in the following cycle
  task automatic reg_rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_sys);
    req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    data = reg_rdata;
  endtask

  // synchronous chip reset for 16 cycles
  task automatic chip_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
  endtask

  // reset values, write-only restart register and unmapped address
  task automatic test_reset_values();
    reg_rd(wdt_pkg::STATUS_ADDR, rd_val);
    check("status", rd_val, 8'h00);
    reg_rd(wdt_pkg::PERIOD_ADDR, rd_val);
    check("period", rd_val & 8'h07, 8'h00);
    reg_rd(wdt_pkg::CLKCTL_ADDR, rd_val);
    check("clkctl", rd_val & 8'h03, 8'h00);
    reg_rd(wdt_pkg::RESTART_ADDR, rd_val);
    check("restart read", rd_val, 8'h00);
    reg_rd(8'h00, rd_val);
    check("unmapped", rd_val, 8'h00);
    reg_wr(wdt_pkg::PERIOD_ADDR, 8'h07);
    reg_rd(wdt_pkg::PERIOD_ADDR, rd_val);
    check("period rw", rd_val & 8'h07, 8'h07);
    reg_wr(wdt_pkg::PERIOD_ADDR, 8'h00);
    reg_wr(wdt_pkg::CLKCTL_ADDR, 8'h01);
    reg_rd(wdt_pkg::CLKCTL_ADDR, rd_val);
    check("clkctl rw", rd_val & 8'h03, 8'h01);
  endtask

  // broken and complete enable sequences, then disable attempts
  task automatic test_sequence();
    reg_wr(wdt_pkg::RESTART_ADDR, wdt_pkg::SEQ_FIRST);
    reg_wr(wdt_pkg::RESTART_ADDR, 8'h55);
    reg_wr(wdt_pkg::RESTART_ADDR, wdt_pkg::SEQ_SECOND);
    reg_rd(wdt_pkg::STATUS_ADDR, rd_val);
    check("broken seq", rd_val[7], 1'b0);
    reg_wr(wdt_pkg::RESTART_ADDR, wdt_pkg::SEQ_FIRST);
    reg_wr(wdt_pkg::PERIOD_ADDR, 8'h00);
    reg_wr(wdt_pkg::RESTART_ADDR, wdt_pkg::SEQ_FIRST);
    reg_wr(wdt_pkg::RESTART_ADDR, wdt_pkg::SEQ_SECOND);
    reg_rd(wdt_pkg::STATUS_ADDR, rd_val);
    check("enable", rd_val[7], 1'b1);
    reg_wr(wdt_pkg::RESTART_ADDR, 8'h00);
    reg_wr(wdt_pkg::STATUS_ADDR, 8'h00);
    reg_rd(wdt_pkg::STATUS_ADDR, rd_val);
    check("no disable", rd_val[7], 1'b1);
  endtask

  // restart, freeze in power-down, overflow time and pulse width
  task automatic test_overflow();
    int cnt;
    int w;
    cnt = 0;
    w = 0;
    // let the running watchdog age, then service it
    repeat (1000) @(posedge clk_sys);
    reg_wr(wdt_pkg::RESTART_ADDR, wdt_pkg::SEQ_FIRST);
    reg_wr(wdt_pkg::RESTART_ADDR, wdt_pkg::SEQ_SECOND);
    #1;
    while (chip_reset_out !== 1'b1 && cnt < 100000) begin
      @(posedge clk_sys);
      if (cnt == 1000) power_down <= 1'b1;
      if (cnt == 1000 + FREEZE_CLKS) power_down <= 1'b0;
      if (cnt == 2000) ce <= 1'b0;
      if (cnt == 2000 + HOLD_CLKS) ce <= 1'b1;
      #1;
      cnt++;
    end
    // a whole step early or late falls outside this window
    check("timeout lo", cnt >= EXPECT_CLKS - 3, 1);
    check("timeout hi", cnt <= EXPECT_CLKS + 3, 1);
    while (chip_reset_out === 1'b1 && w < 1000) begin
      @(posedge clk_sys);
      #1;
      w++;
    end
    check("pulse width", w, wdt_pkg::PULSE_OSC_PERIODS);
    reg_rd(wdt_pkg::STATUS_ADDR, rd_val);
    check("after pulse", rd_val, 8'h00);
  endtask

  // halved clock modes, restart before power-down, reset ends it
  task automatic test_reset_in_power_down();
    reg_wr(wdt_pkg::PERIOD_ADDR, 8'h05);
    reg_wr(wdt_pkg::CLKCTL_ADDR, 8'h03);
    reg_wr(wdt_pkg::RESTART_ADDR, wdt_pkg::SEQ_FIRST);
    reg_wr(wdt_pkg::RESTART_ADDR, wdt_pkg::SEQ_SECOND);
    repeat (60) @(posedge clk_sys);
    reg_wr(wdt_pkg::CLKCTL_ADDR, 8'h00);
    repeat (60) @(posedge clk_sys);
    #1;
    check("no early reset", chip_reset_out, 1'b0);
    reg_rd(wdt_pkg::STATUS_ADDR, rd_val);
    check("slow enable", rd_val[7], 1'b1);
    reg_wr(wdt_pkg::RESTART_ADDR, wdt_pkg::SEQ_FIRST);
    reg_wr(wdt_pkg::RESTART_ADDR, wdt_pkg::SEQ_SECOND);
    @(posedge clk_sys);
    power_down <= 1'b1;
    chip_reset();
    power_down <= 1'b0;
    reg_rd(wdt_pkg::STATUS_ADDR, rd_val);
    check("pd reset status", rd_val, 8'h00);
    reg_rd(wdt_pkg::PERIOD_ADDR, rd_val);
    check("pd reset period", rd_val & 8'h07, 8'h00);
    reg_rd(wdt_pkg::CLKCTL_ADDR, rd_val);
    check("pd reset clkctl", rd_val & 8'h03, 8'h00);
  endtask

  // hang guard, a little over the expected run length
  initial begin
    repeat (104000) @(posedge clk_sys);
    err_count++;
    end_of_test();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    power_down = 1'b0;
    req = '0;
    err_count = 0;
    compares = 0;
    chip_reset();
    test_reset_values();
    test_sequence();
    test_overflow();
    test_reset_in_power_down();
    end_of_test();
  end
endmodule
